// ---- verilog/adc_input_config_and_sequence_loader.v ----
// serial configuration decode, input pairing decode and channel sequence loader
`timescale 1ns/1ps
`include "seq_loader_defines.vh"
module adc_input_config_and_sequence_loader (
    input  wire        I_CLK,
    input  wire        I_RST,
    input  wire        I_SCLK,
    input  wire        I_CS_N,
    input  wire        I_DIN,
    input  wire [3:0]  I_SCAN_MODE,
    input  wire [3:0]  I_CHANNEL_SELECT_FIELD,
    input  wire [7:0]  I_SEQ_INDEX,
    output reg  [15:0] O_CHANNEL_SCAN_MASK,
    output reg  [3:0]  O_CONV_CHANNEL,
    output reg         O_USE_SCAN_MASK,
    output reg         O_CONV_DIFF,
    output reg         O_CONV_BIPOLAR,
    output reg         O_CONV_COMMON_REF,
    output reg  [7:0]  O_PAIR_PSEUDO_DIFF,
    output reg  [7:0]  O_PAIR_BIPOLAR,
    output reg         O_COMMON_REFERENCE_ENABLE,
    output reg  [8:0]  O_SEQUENCE_LENGTH_FIELD,
    output reg         O_SEQ_LOADING,
    output reg  [3:0]  O_SEQ_ENTRY
);
    // ****************************************
    // pin synchronisers and edge detection
    // ****************************************
    reg [1:0] sclk_sync_ff;
    reg [1:0] cs_sync_ff;
    reg [1:0] din_sync_ff;
    reg       sclk_prev_ff;
    reg       cs_prev_ff;
    wire      sclk_rise = sclk_sync_ff[1] & ~sclk_prev_ff;
    wire      cs_fall   = ~cs_sync_ff[1] & cs_prev_ff;
    wire      cs_rise   = cs_sync_ff[1] & ~cs_prev_ff;
    wire      in_frame  = ~cs_sync_ff[1];

    always @(posedge I_CLK) begin
        if (I_RST) begin
            sclk_sync_ff <= 2'h0;
            cs_sync_ff   <= 2'h3;
            din_sync_ff  <= 2'h0;
            sclk_prev_ff <= 1'b0;
            cs_prev_ff   <= 1'b1;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[0], I_SCLK};
            cs_sync_ff   <= {cs_sync_ff[0], I_CS_N};
            din_sync_ff  <= {din_sync_ff[0], I_DIN};
            sclk_prev_ff <= sclk_sync_ff[1];
            cs_prev_ff   <= cs_sync_ff[1];
        end
    end

    // ****************************************
    // frame state and word shifter
    // ****************************************
    localparam ST_WORD = 3'h1;
    localparam ST_PATT = 3'h2;
    localparam ST_FILL = 3'h4;

    reg [2:0]  state_ff;
    reg [15:0] shift_ff;
    reg [3:0]  bit_cnt_ff;
    reg        word_done_ff;
    reg        patt_armed_ff;
    reg [7:0]  len_field_ff;
    reg [7:0]  wr_ptr_ff;
    reg [8:0]  fill_cnt_ff;
    reg        patt_over_ff;
    reg [3:0]  nib_ff;
    reg [1:0]  nib_cnt_ff;
    reg        we;
    reg [7:0]  waddr;
    reg [3:0]  wdata;
    reg        pending_ff;
    reg [7:0]  pend_len_ff;
    wire [15:0] word_in = {shift_ff[14:0], din_sync_ff[1]};
    wire [4:0]  sel_code = word_in[`SEL_HI:`SEL_LO];

    always @* begin
        we    = 1'b0;
        waddr = wr_ptr_ff;
        wdata = 4'h0;
        if (state_ff == ST_PATT && in_frame && sclk_rise && !patt_over_ff &&
            nib_cnt_ff == 2'h3) begin
            we    = 1'b1;
            wdata = {nib_ff[2:0], din_sync_ff[1]};
        end else if (state_ff == ST_FILL) begin
            we    = 1'b1;
            wdata = 4'h0;
        end
    end

    always @(posedge I_CLK) begin
        if (I_RST) begin
            state_ff      <= ST_WORD;
            shift_ff      <= 16'h0000;
            bit_cnt_ff    <= 4'h0;
            word_done_ff  <= 1'b0;
            patt_armed_ff <= 1'b0;
            len_field_ff  <= `RST_LEN;
            wr_ptr_ff     <= 8'h00;
            fill_cnt_ff   <= 9'h000;
            patt_over_ff  <= 1'b0;
            nib_ff        <= 4'h0;
            nib_cnt_ff    <= 2'h0;
            pending_ff    <= 1'b0;
            pend_len_ff   <= `RST_LEN;
            O_PAIR_PSEUDO_DIFF        <= `RST_PAIRS;
            O_PAIR_BIPOLAR            <= `RST_PAIRS;
            O_COMMON_REFERENCE_ENABLE <= 1'b0;
            O_CHANNEL_SCAN_MASK       <= 16'h0000;
            O_SEQUENCE_LENGTH_FIELD              <= 9'h001;
            O_SEQ_LOADING             <= 1'b0;
        end else begin
            // frame start: pattern frame follows a length frame
            if (cs_fall) begin
                bit_cnt_ff   <= 4'h0;
                word_done_ff <= 1'b0;
                nib_cnt_ff   <= 2'h0;
                wr_ptr_ff    <= 8'h00;
                patt_over_ff <= 1'b0;
                if (pending_ff) begin
                    O_SEQUENCE_LENGTH_FIELD <= {1'b0, pend_len_ff} + 9'h001;
                    pending_ff   <= 1'b0;
                end
                if (patt_armed_ff) begin
                    state_ff      <= ST_PATT;
                    patt_armed_ff <= 1'b0;
                    O_SEQ_LOADING <= 1'b1;
                end else begin
                    state_ff <= ST_WORD;
                end
            end else if (state_ff == ST_WORD && in_frame && sclk_rise && !word_done_ff) begin
                shift_ff   <= word_in;
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                if (bit_cnt_ff == 4'hF) begin
                    word_done_ff <= 1'b1;
                    if (word_in[15]) begin
                        case (sel_code)
                            `CODE_PAIRING: begin
                                O_PAIR_PSEUDO_DIFF <= word_in[`PAIR_HI:`PAIR_LO];
                                O_COMMON_REFERENCE_ENABLE <= word_in[`COMREF_BIT];
                            end
                            `CODE_BIPOLAR: begin
                                O_PAIR_BIPOLAR <= word_in[`PAIR_HI:`PAIR_LO];
                            end
                            `CODE_CUST0: begin
                                O_CHANNEL_SCAN_MASK[15:8] <= word_in[`PAIR_HI:`PAIR_LO];
                            end
                            `CODE_CUST1: begin
                                O_CHANNEL_SCAN_MASK[7:0] <= word_in[`PAIR_HI:`PAIR_LO];
                            end
                            `CODE_SEQUENCE: begin
                                len_field_ff  <= word_in[`PAIR_HI:`PAIR_LO];
                                patt_armed_ff <= 1'b1;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end else if (state_ff == ST_PATT && in_frame && sclk_rise && !patt_over_ff) begin
                nib_ff     <= {nib_ff[2:0], din_sync_ff[1]};
                nib_cnt_ff <= nib_cnt_ff + 2'h1;
                if (nib_cnt_ff == 2'h3) begin
                    wr_ptr_ff <= wr_ptr_ff + 8'h01;
                    if (wr_ptr_ff == len_field_ff) begin
                        patt_over_ff <= 1'b1;
                    end
                end
            end else if (state_ff == ST_PATT && cs_rise) begin
                // remaining entries, partial nibble included, go to channel 0
                if (patt_over_ff) begin
                    state_ff      <= ST_WORD;
                    O_SEQ_LOADING <= 1'b0;
                    pending_ff    <= 1'b1;
                    pend_len_ff   <= len_field_ff;
                end else begin
                    state_ff    <= ST_FILL;
                    fill_cnt_ff <= {1'b0, len_field_ff} - {1'b0, wr_ptr_ff};
                end
            end else if (state_ff == ST_FILL) begin
                wr_ptr_ff   <= wr_ptr_ff + 8'h01;
                fill_cnt_ff <= fill_cnt_ff - 9'h001;
                if (fill_cnt_ff == 9'h000) begin
                    state_ff      <= ST_WORD;
                    O_SEQ_LOADING <= 1'b0;
                    pending_ff    <= 1'b1;
                    pend_len_ff   <= len_field_ff;
                end
            end
        end
    end

    // ****************************************
    // sequence memory
    // ****************************************
    wire [3:0] seq_rdata;

    seq_entry_ram u_ram (
        .i_clk   (I_CLK),
        .i_we    (we),
        .i_waddr (waddr),
        .i_wdata (wdata),
        .i_raddr (I_SEQ_INDEX),
        .o_rdata (seq_rdata)
    );

    always @(posedge I_CLK) begin
        if (I_RST) begin
            O_SEQ_ENTRY <= 4'h0;
        end else begin
            O_SEQ_ENTRY <= seq_rdata;
        end
    end

    // ****************************************
    // conversion decode for the selected channel
    // ****************************************
    wire [2:0] pair_idx = I_CHANNEL_SELECT_FIELD[3:1];
    wire       pdiff    = O_PAIR_PSEUDO_DIFF[3'h7 - pair_idx];
    wire       bip      = O_PAIR_BIPOLAR[3'h7 - pair_idx];
    wire       masked   = (I_SCAN_MODE == `MODE_MASKED_A) ||
                          (I_SCAN_MODE == `MODE_MASKED_B);

    always @(posedge I_CLK) begin
        if (I_RST) begin
            O_CONV_CHANNEL    <= 4'h0;
            O_USE_SCAN_MASK   <= 1'b0;
            O_CONV_DIFF       <= 1'b0;
            O_CONV_BIPOLAR    <= 1'b0;
            O_CONV_COMMON_REF <= 1'b0;
        end else begin
            O_CONV_CHANNEL  <= I_CHANNEL_SELECT_FIELD;
            O_USE_SCAN_MASK <= masked;
            if (O_COMMON_REFERENCE_ENABLE) begin
                O_CONV_COMMON_REF <= 1'b1;
                O_CONV_DIFF       <= 1'b0;
                O_CONV_BIPOLAR    <= 1'b0;
            end else begin
                O_CONV_COMMON_REF <= 1'b0;
                O_CONV_DIFF       <= pdiff | bip;
                O_CONV_BIPOLAR    <= bip & ~pdiff;
            end
        end
    end
endmodule

// ---- verilog/seq_loader_defines.vh ----
// constants for the input configuration and sequence loader
`ifndef SEQ_LOADER_DEFINES_VH
`define SEQ_LOADER_DEFINES_VH
`define WORD_W          16
`define SEL_HI          15
`define SEL_LO          11
`define CODE_PAIRING    5'h11
`define CODE_BIPOLAR    5'h12
`define CODE_CUST0      5'h14
`define CODE_CUST1      5'h15
`define CODE_SEQUENCE   5'h16
`define PAIR_HI         10
`define PAIR_LO         3
`define COMREF_BIT      2
`define SEQ_DEPTH       256
`define SEQ_AW          8
`define MODE_W          4
`define MODE_MASKED_A   4'h7
`define MODE_MASKED_B   4'h8
`define RST_PAIRS       8'h00
`define RST_LEN         8'h00
`endif

// ---- verilog/seq_entry_ram.v ----
// sequence entry memory, 256 nibbles, registered read
`timescale 1ns/1ps
module seq_entry_ram (
    input  wire       i_clk,
    input  wire       i_we,
    input  wire [7:0] i_waddr,
    input  wire [3:0] i_wdata,
    input  wire [7:0] i_raddr,
    output reg  [3:0] o_rdata
);
    reg [3:0] mem [0:255];

    // write port and registered read port
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// ---- tb/seq_loader_host.sv ----
// serial host model driving the configuration link
`timescale 1ns/1ps
module seq_loader_host (
    input  wire i_clk,
    output reg  o_sclk,
    output reg  o_cs_n,
    output reg  o_din
);
    // link idle: clock parked low, select high
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
    end
    // one frame of n bits, msb first, 800 ns serial clock
    task automatic frame(input logic [15:0] bits, input int n);
        int k;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        for (k = n - 1; k >= 0; k--) begin
            o_din = bits[k];
            repeat (4) @(negedge i_clk);
            o_sclk = 1'b1;
            repeat (4) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (4) @(negedge i_clk);
        o_cs_n = 1'b1;
        o_din  = ~o_din; // released line shows no stale bit
        repeat (8) @(negedge i_clk);
    endtask
endmodule

// ---- tb/seq_loader_properties.sv ----
// port assertions for the sequence loader
`timescale 1ns/1ps
module seq_loader_props (
    input wire        I_CLK,
    input wire        I_RST,
    input wire [3:0]  I_SCAN_MODE,
    input wire [3:0]  I_CHANNEL_SELECT_FIELD,
    input wire        I_CS_N,
    input wire [3:0]  O_CONV_CHANNEL,
    input wire        O_USE_SCAN_MASK,
    input wire        O_CONV_DIFF,
    input wire        O_CONV_BIPOLAR,
    input wire        O_CONV_COMMON_REF,
    input wire [7:0]  O_PAIR_PSEUDO_DIFF,
    input wire [7:0]  O_PAIR_BIPOLAR,
    input wire        O_COMMON_REFERENCE_ENABLE,
    input wire [8:0]  O_SEQUENCE_LENGTH_FIELD,
    input wire        O_SEQ_LOADING
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // pair bits of the selected channel
    wire pd = O_PAIR_PSEUDO_DIFF[~I_CHANNEL_SELECT_FIELD[3:1]];
    wire bp = O_PAIR_BIPOLAR[~I_CHANNEL_SELECT_FIELD[3:1]];
    wire cm = O_COMMON_REFERENCE_ENABLE;
    property p_chan;
        !$past(I_RST) |-> O_CONV_CHANNEL == $past(I_CHANNEL_SELECT_FIELD);
    endproperty
    a_chan: assert property (p_chan) else $error("channel copy wrong");
    property p_mask;
        !$past(I_RST) |-> O_USE_SCAN_MASK == ($past(I_SCAN_MODE) inside {4'h7, 4'h8});
    endproperty
    a_mask: assert property (p_mask) else $error("mask mode wrong");
    property p_single;
        !$past(I_RST) && !O_USE_SCAN_MASK && !$past(pd | bp | cm)
            |-> !(O_CONV_DIFF | O_CONV_BIPOLAR | O_CONV_COMMON_REF);
    endproperty
    a_single: assert property (p_single) else $error("single ended wrong");
    property p_bip;
        !$past(I_RST) && !O_USE_SCAN_MASK && $past(bp & !pd & !cm)
            |-> O_CONV_DIFF && O_CONV_BIPOLAR;
    endproperty
    a_bip: assert property (p_bip) else $error("bipolar pair wrong");
    property p_uni;
        !$past(I_RST) && !O_USE_SCAN_MASK && $past(pd & !cm) |-> O_CONV_DIFF && !O_CONV_BIPOLAR;
    endproperty
    a_uni: assert property (p_uni) else $error("unipolar pair wrong");
    property p_com;
        !$past(I_RST) && !O_USE_SCAN_MASK && $past(cm)
            |-> O_CONV_COMMON_REF && !O_CONV_DIFF && !O_CONV_BIPOLAR;
    endproperty
    a_com: assert property (p_com) else $error("common reference wrong");
    property p_len;
        !$stable(O_SEQUENCE_LENGTH_FIELD) |-> !I_CS_N && !O_SEQ_LOADING && O_SEQUENCE_LENGTH_FIELD != 9'h000
            && O_SEQUENCE_LENGTH_FIELD <= 9'h100;
    endproperty
    a_len: assert property (p_len) else $error("length change wrong");
    property p_fill;
        $rose(I_CS_N) && O_SEQ_LOADING |-> ##[1:270] !O_SEQ_LOADING;
    endproperty
    a_fill: assert property (p_fill) else $error("fill not finished");
endmodule

// ---- tb/tb.sv ----
// testbench for the input configuration and sequence loader
`timescale 1ns/1ps
module tb;
    logic       clk;
    logic       rst;
    logic [3:0] mode;
    logic [3:0] chan;
    logic [7:0] idx;
    wire        sclk, cs_n, din, use_mask, diff, bip, comref, com_en, loading;
    wire [15:0] scan_mask;
    wire [3:0]  conv_ch, entry;
    wire [7:0]  pdiff, pbip;
    wire [8:0]  seq_len;
    int         n_mismatch = 0;
    int         num_checks = 0;
    seq_loader_host i_host (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
    adc_input_config_and_sequence_loader i_dut (
        .I_CLK(clk), .I_RST(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_DIN(din),
        .I_SCAN_MODE(mode), .I_CHANNEL_SELECT_FIELD(chan), .I_SEQ_INDEX(idx),
        .O_CHANNEL_SCAN_MASK(scan_mask), .O_CONV_CHANNEL(conv_ch), .O_USE_SCAN_MASK(use_mask),
        .O_CONV_DIFF(diff), .O_CONV_BIPOLAR(bip), .O_CONV_COMMON_REF(comref),
        .O_PAIR_PSEUDO_DIFF(pdiff), .O_PAIR_BIPOLAR(pbip), .O_COMMON_REFERENCE_ENABLE(com_en),
        .O_SEQUENCE_LENGTH_FIELD(seq_len), .O_SEQ_LOADING(loading), .O_SEQ_ENTRY(entry));
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // walk all channels against one pairing setup
    task automatic chk_decode(input logic [7:0] pd, input logic [7:0] bp, input logic c);
        logic p, b;
        for (int ch = 0; ch < 16; ch++) begin
            chan = ch[3:0];
            repeat (2) @(negedge clk);
            p = pd[7 - ch / 2];
            b = bp[7 - ch / 2];
            chk(diff, !c && (p || b));
            chk(bip, !c && b && !p);
            chk(comref, c);
            chk(conv_ch, ch[3:0]);
        end
    endtask
    task automatic chk_entries(input logic [23:0] exp, input int n);
        for (int e = 0; e < n; e++) begin
            idx = e[7:0];
            repeat (3) @(negedge clk);
            chk(entry, exp[23 - 4 * e -: 4]);
        end
    endtask
    // bounded wait for the loader to finish its fill
    task automatic wait_idle;
        int t;
        for (t = 0; t < 400 && loading !== 1'b0; t++) @(negedge clk);
        if (t == 400) begin
            n_mismatch++;
            $display("unexpected at %0t: loader stuck", $time);
            test_done;
        end
    endtask
    task automatic load(input logic [15:0] len_w, input logic [15:0] pat, input int n);
        i_host.frame(len_w, 16);
        i_host.frame(pat, n);
        wait_idle;
    endtask
    initial begin
        rst = 1'b1;
        mode = 4'h0;
        chan = 4'h0;
        idx = 8'h00;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk(pdiff, 8'h00);
        chk(com_en, 1'b0);
        chk(seq_len, 9'h001);
        $display("test reset done");
        i_host.frame(16'h8D2C, 16);
        i_host.frame(16'h0D20, 16);
        i_host.frame(16'h9FF8, 16);
        chk(pdiff, 8'hA5);
        chk(com_en, 1'b1);
        chk_decode(8'hA5, 8'h00, 1'b1);
        i_host.frame(16'h91E0, 16);
        i_host.frame(16'h8878, 16);
        chk(pbip, 8'h3C);
        chk_decode(8'h0F, 8'h3C, 1'b0);
        $display("test pairing done");
        i_host.frame(16'hA618, 16);
        i_host.frame(16'hAC08, 16);
        chk(scan_mask, 16'hC381);
        for (int m = 0; m < 16; m++) begin
            mode = m[3:0];
            repeat (2) @(negedge clk);
            chk(use_mask, m == 7 || m == 8);
        end
        mode = 4'h0;
        $display("test scan done");
        load(16'hB028, 16'h27CE, 14);
        chk(seq_len, 9'h001);
        i_host.frame(16'h0000, 16);
        chk(seq_len, 9'h006);
        chk_entries(24'h9F3000, 6);
        load(16'hB008, 16'h5A77, 16);
        i_host.frame(16'h0000, 16);
        chk(seq_len, 9'h002);
        chk_entries(24'h5A3000, 3);
        // full length with one nibble: long fill still running after the frame
        i_host.frame(16'hB7F8, 16);
        i_host.frame(16'h000C, 4);
        chk(loading, 1'b1);
        wait_idle;
        i_host.frame(16'h0000, 16);
        chk(seq_len, 9'h100);
        chk_entries(24'hC00000, 6);
        $display("test sequence done");
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(seq_len, 9'h001);
        chk(pdiff, 8'h00);
        $display("test second reset done");
        test_done;
    end
endmodule
bind adc_input_config_and_sequence_loader seq_loader_props i_props (
    .I_CLK                     (I_CLK),
    .I_RST                     (I_RST),
    .I_SCAN_MODE               (I_SCAN_MODE),
    .I_CHANNEL_SELECT_FIELD    (I_CHANNEL_SELECT_FIELD),
    .I_CS_N                    (I_CS_N),
    .O_CONV_CHANNEL            (O_CONV_CHANNEL),
    .O_USE_SCAN_MASK           (O_USE_SCAN_MASK),
    .O_CONV_DIFF               (O_CONV_DIFF),
    .O_CONV_BIPOLAR            (O_CONV_BIPOLAR),
    .O_CONV_COMMON_REF         (O_CONV_COMMON_REF),
    .O_PAIR_PSEUDO_DIFF        (O_PAIR_PSEUDO_DIFF),
    .O_PAIR_BIPOLAR            (O_PAIR_BIPOLAR),
    .O_COMMON_REFERENCE_ENABLE (O_COMMON_REFERENCE_ENABLE),
    .O_SEQUENCE_LENGTH_FIELD              (O_SEQUENCE_LENGTH_FIELD),
    .O_SEQ_LOADING             (O_SEQ_LOADING)
);
